// file: hdl/dpll_hist_pkg.sv
// Constants, field layout and carrier types for the loop state and history block
// Notes on behaviour
// R1: Average loop tuning words over each interval, store in holdover_average_word.
// R2: Each interval average uses only its own samples, never earlier ones.
// R3: Interval end gives a strobe setting the history-updated flag when its mask allows.
// R4: History-update strobe can be routed to a multipurpose pin output.
// R5: A change to another reference restarts history accumulation.
// R6: Writing one to loop control bit 2 erases the stored history.
// R7: A multipurpose pin configured as clear input also erases the history.
// R8: Reference switch erases history unless the persistent-history bit is set.
// R9: With no history, nothing is stored before a full interval, unless K is nonzero.
// R10: Field K picks intermediate averages in the first interval after a clear only.
// R11: Intermediate averages at interval/2^K, doubling to the full interval, then evenly.
// R12: State machine handles reference changes and holdover entry and exit by itself.
// R13: Each loop state change applies the newly active reference's profile; the code loads it only on entry to closed loop.
// R14: Software may force holdover, free-run or a chosen reference via loop_mode.
// R15: Switchover passes briefly through holdover, then closes the loop on the new reference.
// R16: Lock status outputs stay frozen during a switchover.
// R17: Holdover is open loop with constant word, the latest stored average if any.
// R18: Holdover without history and fallback bit clear uses the free-run word.
// R19: Holdover without history and fallback bit set keeps the last applied word.
// R20: Valid reference in automatic holdover returns loop to closed operation with its profile.
// R21: User-holdover bit set blocks automatic holdover exit until software clears it.
// R22: Software should clear history after phase lock to drop acquisition transients.
// R23: Interval is a 24-bit millisecond timer; zero must never be programmed.
// R24: Free-run or holdover reports the phase lock detector as unlocked.
// R25: Free-run uses the free-run word directly; closed loop uses loop filter output.
// R26: History register updates all bytes in one cycle, never a byte mix.
package dpll_hist_pkg;
  localparam int          ADDR_W           = 12;
  localparam int          DATA_W           = 8;
  localparam int          FTW_W            = 48;
  localparam int          FTW_BYTES        = 6;
  localparam int          AVG_W            = 24;
  localparam int          AVG_BYTES        = 3;
  localparam logic [11:0] FRW_ADDR         = 12'h0300;
  localparam logic [11:0] AVG_INT_ADDR     = 12'h0318;
  localparam logic [11:0] HIST_MODE_ADDR   = 12'h031B;
  localparam logic [11:0] LOOP_MODE_ADDR   = 12'h0A01;
  localparam logic [11:0] LOOP_CTRL_ADDR   = 12'h0A03;
  localparam logic [11:0] HIST_ADDR        = 12'h0D14;
  localparam logic [11:0] STATUS_ADDR      = 12'h0D20;
  localparam logic [11:0] EVT_MASK_ADDR    = 12'h0D21;
  localparam logic [11:0] EVT_FLAG_ADDR    = 12'h0D22;
  localparam logic [11:0] MP_CFG_ADDR      = 12'h0D23;
  localparam int          HM_K_LSB         = 0;
  localparam int          HM_K_W           = 3;
  localparam int          HM_PERSIST_BIT   = 3;
  localparam int          HM_FALLBACK_BIT  = 4;
  localparam int          LM_REF_LSB       = 0;
  localparam int          LM_FORCE_REF_BIT = 2;
  localparam int          LM_FREE_RUN_BIT  = 5;
  localparam int          LM_USER_HOLD_BIT = 6;
  localparam int          LC_CLEAR_BIT     = 2;
  localparam int          EVT_HIST_BIT     = 0;
  localparam int          MP_STROBE_BIT    = 0;
  localparam int          MP_CLEAR_BIT     = 1;
  localparam logic [7:0]  BYTE_RST         = 8'h00;
  localparam logic [23:0] AVG_INT_RST      = 24'h00_03E8;
  localparam int          MS_NS            = 1000000;
  localparam int          CLK_NS           = 40;
  localparam int          CYC_PER_MS       = MS_NS / CLK_NS;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

  typedef struct packed {
    logic phase;
    logic freq;
  } lock_t;
endpackage

// file: hdl/dpll_holdover_history_control.sv
// Loop state control, reference switchover, holdover and tuning word history averaging
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
module dpll_holdover_history_control #(
  parameter int NUM_REF    = 4,
  parameter int REF_W      = 2,
  parameter int CNT_W      = 24,
  parameter int CYC_PER_MS = dpll_hist_pkg::CYC_PER_MS
) (
  input  wire logic                             sys_clk_i,
  input  wire logic                             rst_i,
  input  wire dpll_hist_pkg::reg_req_t          reg_req_i,
  output logic [dpll_hist_pkg::DATA_W-1:0]      reg_rdata_o,
  input  wire logic [NUM_REF-1:0]               ref_valid_i,
  input  wire logic [dpll_hist_pkg::FTW_W-1:0]  loop_ftw_i,
  input  wire logic                             loop_ftw_vld_i,
  input  wire dpll_hist_pkg::lock_t             lock_i,
  input  wire logic                             mp_clear_i,
  output logic                                  hist_strobe_o,
  output dpll_hist_pkg::lock_t                  lock_o,
  output logic [dpll_hist_pkg::FTW_W-1:0]       synth_ftw_o,
  output logic [REF_W-1:0]                      active_ref_o,
  output logic                                  profile_load_o
);
  localparam int FW    = dpll_hist_pkg::FTW_W;
  localparam int SUM_W = FW + CNT_W;
  localparam int MS_W  = $clog2(CYC_PER_MS + 1);
  localparam int DIV_W = $clog2(SUM_W + 1);
  localparam logic [MS_W-1:0]  MS_LAST  = MS_W'(CYC_PER_MS - 1);
  localparam logic [DIV_W-1:0] DIV_STEP = DIV_W'(SUM_W);

  typedef enum logic [1:0] {FREE_RUN, CLOSED, SWITCH, HOLD} loop_st_t;

  loop_st_t            st_r, st_nxt;
  logic [FW-1:0]       frw_r, hist_r, hold_ftw_r, synth_r;
  logic [23:0]         avg_int_r, elapsed_r;
  logic [7:0]          hist_mode_r, loop_mode_r, evt_mask_r, mp_cfg_r, rdata_r;
  logic                evt_flag_r, hist_valid_r, first_r, strobe_r, load_r;
  logic [2:0]          shift_r, mp_sync_r;
  logic                clr_lvl_r;
  logic [MS_W-1:0]     ms_cnt_r;
  logic [SUM_W-1:0]    acc_r, quo_r;
  logic [CNT_W-1:0]    cnt_r, den_r;
  logic [CNT_W:0]      rem_r;
  logic [DIV_W-1:0]    div_cnt_r;
  logic                div_busy_r;
  logic [REF_W-1:0]    active_r;
  dpll_hist_pkg::lock_t lock_r;

  // Register decode
  wire [11:0] addr     = reg_req_i.addr;
  wire [11:0] frw_off  = addr - dpll_hist_pkg::FRW_ADDR;
  wire [11:0] avg_off  = addr - dpll_hist_pkg::AVG_INT_ADDR;
  wire [11:0] hist_off = addr - dpll_hist_pkg::HIST_ADDR;
  wire in_frw  = (addr >= dpll_hist_pkg::FRW_ADDR) && (frw_off < 12'(dpll_hist_pkg::FTW_BYTES));
  wire in_avg  = (addr >= dpll_hist_pkg::AVG_INT_ADDR)
                 && (avg_off < 12'(dpll_hist_pkg::AVG_BYTES));
  wire in_hist = (addr >= dpll_hist_pkg::HIST_ADDR) && (hist_off < 12'(dpll_hist_pkg::FTW_BYTES));
  wire wr_hm   = reg_req_i.wr && (addr == dpll_hist_pkg::HIST_MODE_ADDR);
  wire wr_lm   = reg_req_i.wr && (addr == dpll_hist_pkg::LOOP_MODE_ADDR);
  wire wr_mask = reg_req_i.wr && (addr == dpll_hist_pkg::EVT_MASK_ADDR);
  wire wr_flag = reg_req_i.wr && (addr == dpll_hist_pkg::EVT_FLAG_ADDR);
  wire wr_mp   = reg_req_i.wr && (addr == dpll_hist_pkg::MP_CFG_ADDR);
  wire sw_clr  = reg_req_i.wr && (addr == dpll_hist_pkg::LOOP_CTRL_ADDR)
                 && reg_req_i.wdata[dpll_hist_pkg::LC_CLEAR_BIT]; // R6

  // Control fields
  wire [2:0]       k_fld      = hist_mode_r[dpll_hist_pkg::HM_K_LSB +: dpll_hist_pkg::HM_K_W];
  wire             persist    = hist_mode_r[dpll_hist_pkg::HM_PERSIST_BIT];
  wire             fallback   = hist_mode_r[dpll_hist_pkg::HM_FALLBACK_BIT];
  wire [REF_W-1:0] lm_ref     = loop_mode_r[dpll_hist_pkg::LM_REF_LSB +: REF_W];
  wire             force_ref  = loop_mode_r[dpll_hist_pkg::LM_FORCE_REF_BIT];
  wire             force_free = loop_mode_r[dpll_hist_pkg::LM_FREE_RUN_BIT];
  wire             user_hold  = loop_mode_r[dpll_hist_pkg::LM_USER_HOLD_BIT];

  // Read mux, answered one cycle after the strobe
  wire [7:0] status_byte = {div_busy_r, lock_r.freq, lock_r.phase, hist_valid_r,
                            2'(active_r), (st_r == HOLD) || (st_r == SWITCH), st_r == FREE_RUN};
  wire [7:0] rd_nxt =
    in_frw  ? frw_r[{frw_off[2:0], 3'b000} +: 8] :
    in_avg  ? avg_int_r[{avg_off[1:0], 3'b000} +: 8] :
    in_hist ? hist_r[{hist_off[2:0], 3'b000} +: 8] :
    (addr == dpll_hist_pkg::HIST_MODE_ADDR) ? hist_mode_r :
    (addr == dpll_hist_pkg::LOOP_MODE_ADDR) ? loop_mode_r :
    (addr == dpll_hist_pkg::STATUS_ADDR)    ? status_byte :
    (addr == dpll_hist_pkg::EVT_MASK_ADDR)  ? evt_mask_r :
    (addr == dpll_hist_pkg::EVT_FLAG_ADDR)  ? {7'h00, evt_flag_r} :
    (addr == dpll_hist_pkg::MP_CFG_ADDR)    ? mp_cfg_r : dpll_hist_pkg::BYTE_RST;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_r <= dpll_hist_pkg::BYTE_RST;
    end else begin
      rdata_r <= reg_req_i.rd ? rd_nxt : dpll_hist_pkg::BYTE_RST;
    end
  end

  // Byte-wide writable words
  genvar g;
  generate
    for (g = 0; g < dpll_hist_pkg::FTW_BYTES; g++) begin : g_frw
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          frw_r[8*g +: 8] <= dpll_hist_pkg::BYTE_RST;
        end else if (reg_req_i.wr && in_frw && (frw_off[2:0] == 3'(g))) begin
          frw_r[8*g +: 8] <= reg_req_i.wdata;
        end
      end
    end
    for (g = 0; g < dpll_hist_pkg::AVG_BYTES; g++) begin : g_avg
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          avg_int_r[8*g +: 8] <= dpll_hist_pkg::AVG_INT_RST[8*g +: 8];
        end else if (reg_req_i.wr && in_avg && (avg_off[1:0] == 2'(g))) begin
          avg_int_r[8*g +: 8] <= reg_req_i.wdata; // R23
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      hist_mode_r <= dpll_hist_pkg::BYTE_RST;
      loop_mode_r <= dpll_hist_pkg::BYTE_RST;
      evt_mask_r  <= dpll_hist_pkg::BYTE_RST;
      mp_cfg_r    <= dpll_hist_pkg::BYTE_RST;
    end else begin
      if (wr_hm)   hist_mode_r <= reg_req_i.wdata;
      if (wr_lm)   loop_mode_r <= reg_req_i.wdata; // R14
      if (wr_mask) evt_mask_r  <= reg_req_i.wdata;
      if (wr_mp)   mp_cfg_r    <= reg_req_i.wdata;
    end
  end

  // Clear pin: three stages, level taken once stages two and three agree
  wire clr_lvl_nxt = (mp_sync_r[1] == mp_sync_r[2]) ? mp_sync_r[2] : clr_lvl_r;
  wire pin_clr     = clr_lvl_nxt && !clr_lvl_r && mp_cfg_r[dpll_hist_pkg::MP_CLEAR_BIT]; // R7
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mp_sync_r <= 3'h0;
      clr_lvl_r <= 1'b0;
    end else begin
      mp_sync_r <= {mp_sync_r[1:0], mp_clear_i};
      clr_lvl_r <= clr_lvl_nxt;
    end
  end

  // Reference choice: forced one, else lowest valid index
  function automatic logic [REF_W-1:0] lowest_valid(input logic [NUM_REF-1:0] v);
    lowest_valid = '0;
    for (int i = NUM_REF - 1; i >= 0; i--) begin
      if (v[i]) lowest_valid = REF_W'(i);
    end
  endfunction
  wire [REF_W-1:0] cand_ref = force_ref ? lm_ref : lowest_valid(ref_valid_i);
  wire             cand_ok  = force_ref ? ref_valid_i[lm_ref] : |ref_valid_i;

  // Loop state machine
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      FREE_RUN: if (!force_free) st_nxt = HOLD;
      CLOSED: begin
        if (force_free) st_nxt = FREE_RUN; // R14
        else if (user_hold || !cand_ok) st_nxt = HOLD; // R12
        else if (cand_ref != active_r) st_nxt = SWITCH; // R15
      end
      SWITCH: st_nxt = force_free ? FREE_RUN : CLOSED; // R15
      HOLD: begin
        if (force_free) st_nxt = FREE_RUN;
        else if (!user_hold && cand_ok) st_nxt = CLOSED; // R20 R21
      end
    endcase
  end

  wire in_hold_nxt = (st_nxt == HOLD) || (st_nxt == SWITCH);
  wire in_hold_cur = (st_r == HOLD) || (st_r == SWITCH);
  wire enter_hold  = in_hold_nxt && !in_hold_cur;
  wire load_evt    = (st_nxt == CLOSED) && (st_r != CLOSED); // R13
  wire ref_change  = load_evt && (cand_ref != active_r); // R5
  wire hist_clr    = sw_clr || pin_clr || (ref_change && !persist); // R6 R7 R8
  wire acc_restart = hist_clr || ref_change; // R5

  // Holdover word chosen at entry and then frozen
  wire [FW-1:0] hold_cap  = hist_valid_r ? hist_r : (fallback ? synth_r : frw_r); // R17 R18 R19
  wire [FW-1:0] hold_word = enter_hold ? hold_cap : hold_ftw_r;
  wire [FW-1:0] synth_nxt = (st_nxt == FREE_RUN) ? frw_r :
                            (st_nxt == CLOSED)   ? loop_ftw_i : hold_word; // R25 R17

  dpll_hist_pkg::lock_t lock_nxt;
  assign lock_nxt.phase = (st_nxt == CLOSED) ? lock_i.phase :
                          (st_nxt == SWITCH) ? lock_r.phase : 1'b0; // R16 R24
  assign lock_nxt.freq  = (st_nxt == SWITCH) ? lock_r.freq : lock_i.freq; // R16

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_r       <= HOLD;
      active_r   <= '0;
      load_r     <= 1'b0;
      hold_ftw_r <= '0;
      synth_r    <= '0;
      lock_r     <= '0;
    end else begin
      st_r       <= st_nxt;
      load_r     <= load_evt;
      hold_ftw_r <= hold_word;
      synth_r    <= synth_nxt;
      lock_r     <= lock_nxt;
      if (load_evt) active_r <= cand_ref; // R13 R20
    end
  end

  // Millisecond tick, runs only while the loop is closed
  wire ms_tick = (st_r == CLOSED) && (ms_cnt_r == MS_LAST);
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || acc_restart || (st_r != CLOSED)) begin
      ms_cnt_r <= '0;
    end else begin
      ms_cnt_r <= ms_tick ? '0 : ms_cnt_r + MS_W'(1);
    end
  end

  // Interval and intermediate checkpoints
  wire [23:0] elapsed_nxt = elapsed_r + 24'h00_0001;
  wire [23:0] mid_target  = avg_int_r >> shift_r;
  wire        full_end    = ms_tick && (elapsed_nxt >= avg_int_r); // R1 R9
  wire        mid_end     = first_r && (shift_r != 3'h0) && (mid_target != 24'h00_0000)
                            && (elapsed_r >= mid_target) && !div_busy_r; // R10 R11
  wire        take        = (full_end || mid_end) && !acc_restart;
  wire        add         = (st_r == CLOSED) && loop_ftw_vld_i;
  wire [SUM_W-1:0] acc_sum = acc_r + SUM_W'(add ? loop_ftw_i : '0);
  wire [CNT_W-1:0] cnt_sum = cnt_r + CNT_W'(add);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || acc_restart) begin
      acc_r     <= '0;
      cnt_r     <= '0;
      elapsed_r <= '0;
      first_r   <= rst_i || hist_clr; // R10
      shift_r   <= rst_i ? 3'h0 : k_fld;
    end else if (full_end) begin
      acc_r     <= '0; // R2
      cnt_r     <= '0;
      elapsed_r <= '0;
      first_r   <= 1'b0; // R11
      shift_r   <= 3'h0;
    end else begin
      acc_r     <= acc_sum;
      cnt_r     <= cnt_sum;
      if (ms_tick) elapsed_r <= elapsed_nxt;
      if (mid_end) shift_r <= shift_r - 3'h1; // R11
    end
  end

  // Serial restoring divider; a clear aborts it so no stale mean lands
  wire [CNT_W+1:0] trial = {rem_r, quo_r[SUM_W-1]} - {2'b00, den_r};
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || acc_restart) begin
      div_busy_r <= 1'b0;
      div_cnt_r  <= '0;
      quo_r      <= '0;
      rem_r      <= '0;
      den_r      <= '0;
    end else if (take) begin
      div_busy_r <= 1'b1;
      div_cnt_r  <= DIV_STEP;
      quo_r      <= acc_sum;
      rem_r      <= '0;
      den_r      <= cnt_sum;
    end else if (div_busy_r) begin
      div_cnt_r  <= div_cnt_r - DIV_W'(1);
      div_busy_r <= div_cnt_r != DIV_W'(1);
      quo_r      <= {quo_r[SUM_W-2:0], !trial[CNT_W+1]};
      rem_r      <= trial[CNT_W+1] ? {rem_r[CNT_W-1:0], quo_r[SUM_W-1]} : trial[CNT_W:0];
    end
  end

  // An abort in the last step must not leave a strobe behind
  wire div_done = div_busy_r && (div_cnt_r == DIV_W'(1)) && !acc_restart;
  wire [SUM_W-1:0] quo_fin = {quo_r[SUM_W-2:0], !trial[CNT_W+1]};
  wire store = div_done && (den_r != '0);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      hist_r       <= '0;
      hist_valid_r <= 1'b0;
      strobe_r     <= 1'b0;
      evt_flag_r   <= 1'b0;
    end else begin
      strobe_r <= div_done; // R3
      if (store) hist_r <= quo_fin[FW-1:0]; // R1 R26
      if (hist_clr) hist_valid_r <= 1'b0; // R6 R8
      else if (store) hist_valid_r <= 1'b1; // R9
      // Set beats a same-cycle write-one clear
      if (div_done && evt_mask_r[dpll_hist_pkg::EVT_HIST_BIT]) evt_flag_r <= 1'b1; // R3
      else if (wr_flag && reg_req_i.wdata[dpll_hist_pkg::EVT_HIST_BIT]) evt_flag_r <= 1'b0;
    end
  end

  assign reg_rdata_o    = rdata_r;
  assign hist_strobe_o  = strobe_r && mp_cfg_r[dpll_hist_pkg::MP_STROBE_BIT]; // R4
  assign lock_o         = lock_r;
  assign synth_ftw_o    = synth_r;
  assign active_ref_o   = active_r;
  assign profile_load_o = load_r;

  // Checks
  property p_switch_freeze;
    @(posedge sys_clk_i) disable iff (rst_i)
      (st_r == SWITCH) |-> (lock_o == $past(lock_o));
  endproperty
  a_switch_freeze: assert property (p_switch_freeze) else $error("lock moved in switch"); // R16

  property p_hold_unlock;
    @(posedge sys_clk_i) disable iff (rst_i)
      (st_r == HOLD || st_r == FREE_RUN) |-> !lock_o.phase;
  endproperty
  a_hold_unlock: assert property (p_hold_unlock) else $error("phase lock shown open loop"); // R24

  property p_free_word;
    @(posedge sys_clk_i) disable iff (rst_i)
      (st_r == FREE_RUN) && $stable(frw_r) |-> (synth_ftw_o == frw_r);
  endproperty
  a_free_word: assert property (p_free_word) else $error("free-run word not applied"); // R25

  property p_hold_const;
    @(posedge sys_clk_i) disable iff (rst_i)
      (st_r == HOLD) ##1 (st_r == HOLD) |-> $stable(synth_ftw_o);
  endproperty
  a_hold_const: assert property (p_hold_const) else $error("holdover word changed"); // R17

  property p_sw_clear;
    @(posedge sys_clk_i) disable iff (rst_i)
      sw_clr |=> !hist_valid_r && (elapsed_r == 24'h00_0000);
  endproperty
  a_sw_clear: assert property (p_sw_clear) else $error("history not erased"); // R6

  property p_user_hold;
    @(posedge sys_clk_i) disable iff (rst_i)
      (st_r == HOLD) && user_hold && !force_free && !wr_lm |=> (st_r == HOLD);
  endproperty
  a_user_hold: assert property (p_user_hold) else $error("left user holdover"); // R21

  property p_flag_set;
    @(posedge sys_clk_i) disable iff (rst_i)
      div_done && evt_mask_r[dpll_hist_pkg::EVT_HIST_BIT] |=> evt_flag_r && strobe_r;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("history flag not set"); // R3

  property p_switch_erase;
    @(posedge sys_clk_i) disable iff (rst_i)
      ref_change && !persist |=> !hist_valid_r ##[1:3] (st_r == CLOSED || st_r == FREE_RUN
                                                       || st_r == HOLD);
  endproperty
  a_switch_erase: assert property (p_switch_erase) else $error("switch kept history"); // R8

  property p_store_atomic;
    @(posedge sys_clk_i) disable iff (rst_i)
      store |=> (hist_r == $past(quo_fin[FW-1:0])) && hist_valid_r;
  endproperty
  a_store_atomic: assert property (p_store_atomic) else $error("history store wrong"); // R26

  c_switch: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    (st_r == CLOSED) ##1 (st_r == SWITCH) ##1 (st_r == CLOSED));
  c_store: cover property (@(posedge sys_clk_i) disable iff (rst_i) store && first_r);
  c_recover: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    (st_r == HOLD) && hist_valid_r ##1 (st_r == CLOSED));
endmodule // dpll_holdover_history_control

// file: hdl/unused_placeholder_none.sv
// Empty on purpose: all logic of the block lives in the main design file

// file: testbench/dpll_ref_source.sv
// Far side model: reference validity, loop filter words and lock levels
`timescale 1ns/1ps
module dpll_ref_source (
  input  wire logic            clk_i,
  input  wire logic [3:0]      ref_en_i,
  input  wire logic [47:0]     word_i,
  output logic [3:0]           ref_valid_o,
  output logic [47:0]          loop_ftw_o,
  output logic                 ftw_vld_o,
  output dpll_hist_pkg::lock_t lock_o
);
  // Samples on every other cycle, slower than the system clock
  initial ftw_vld_o = 1'b0;
  always @(posedge clk_i) begin
    ftw_vld_o <= ~ftw_vld_o;
  end
  assign ref_valid_o = ref_en_i;
  assign loop_ftw_o  = word_i;
  // Detectors report lock whenever any reference is present
  assign lock_o      = '{phase: |ref_en_i, freq: |ref_en_i};
endmodule // dpll_ref_source

// file: testbench/dpll_holdover_history_control_tb_top.sv
// Self-checking bench for the loop state and history block
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
`define WAIT(s, n) begin int k; for (k = 0; k < n && s !== 1'b1; k++) begin \
  @(posedge sys_clk_i); #1; end if (s !== 1'b1) begin num_errors++; summarize(); end end
module dpll_holdover_history_control_tb_top;
  localparam logic [47:0] C1  = 48'h0000_1111_2222;
  localparam logic [47:0] C2  = 48'h0000_3333_4444;
  localparam logic [47:0] FRW = 48'h0000_0ABC_DEF0;
  logic                    sys_clk_i = 1'b0;
  logic                    rst_i     = 1'b1;
  dpll_hist_pkg::reg_req_t req       = '0;
  logic [7:0]              reg_rdata_o;
  logic [3:0]              ref_en    = 4'h0;
  logic [47:0]             word      = 48'h0000_0000_0000;
  logic [3:0]              ref_valid;
  logic [47:0]             loop_ftw, synth_ftw_o, v;
  logic                    ftw_vld, hist_strobe_o, profile_load_o;
  logic                    mp_clear  = 1'b0;
  logic [1:0]              active_ref_o;
  dpll_hist_pkg::lock_t    lock_in, lock_o;
  logic [7:0]              b;
  logic [19:0]             regs [7] = '{20'h3_1B00, 20'hA_0100, 20'h3_18E8, 20'h3_1903,
                                        20'h3_1A00, 20'hF_FF00, 20'hD_1400};
  int                      num_errors = 0;
  int                      tests_run  = 0;
  int                      c;
  always #20 sys_clk_i = ~sys_clk_i;
  dpll_ref_source u_src (.clk_i(sys_clk_i), .ref_en_i(ref_en), .word_i(word),
    .ref_valid_o(ref_valid), .loop_ftw_o(loop_ftw), .ftw_vld_o(ftw_vld), .lock_o(lock_in));
  dpll_holdover_history_control #(.CYC_PER_MS(200)) u_dut (.sys_clk_i(sys_clk_i),
    .rst_i(rst_i), .reg_req_i(req), .reg_rdata_o(reg_rdata_o), .ref_valid_i(ref_valid),
    .loop_ftw_i(loop_ftw), .loop_ftw_vld_i(ftw_vld), .lock_i(lock_in), .mp_clear_i(mp_clear),
    .hist_strobe_o(hist_strobe_o), .lock_o(lock_o), .synth_ftw_o(synth_ftw_o),
    .active_ref_o(active_ref_o), .profile_load_o(profile_load_o));
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk_i);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk_i);
    req.rd <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  // Little endian, lowest address holds bits 7:0
  task automatic wr48(input logic [11:0] a, input logic [47:0] d);
    for (int i = 0; i < 6; i++) wr(a + 12'(i), d[8*i +: 8]);
  endtask
  task automatic rd48(input logic [11:0] a, output logic [47:0] d);
    logic [7:0] t;
    for (int i = 0; i < 6; i++) begin
      rd(a + 12'(i), t);
      d[8*i +: 8] = t;
    end
  endtask
  task automatic count_strobes(input int n, output int cnt);
    cnt = 0;
    repeat (n) begin
      @(posedge sys_clk_i);
      #1 if (hist_strobe_o === 1'b1) cnt++;
    end
  endtask
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    foreach (regs[i]) begin
      rd(regs[i][19:8], b);
      `CHK(b, regs[i][7:0])
    end
    wr(12'h0D14, 8'h55);
    rd(12'h0D14, b);
    `CHK(b, 8'h00)
    wr48(12'h0300, FRW);
    // Holdover since reset keeps the zero word that reset loads
    `CHK(synth_ftw_o, 48'h0000_0000_0000)
    wr(12'h0318, 8'h02);
    wr(12'h0319, 8'h00);
    wr(12'h0D21, 8'h01);
    wr(12'h0D23, 8'h01);
    word <= C1;
    ref_en <= 4'h1;
    `WAIT(profile_load_o, 10)
    `CHK(synth_ftw_o, C1)
    `CHK(lock_o.phase, 1'b1)
    $display("Test closed loop done");
    // Clear aligns the window with the first interval
    for (int kk = 0; kk < 2; kk++) begin
      wr(12'h031B, 8'(kk));
      wr(12'h0A03, 8'h04);
      count_strobes(600, c);
      `CHK(c, kk + 1)
    end
    wr(12'h031B, 8'h00);
    rd48(12'h0D14, v);
    `CHK(v, C1)
    rd(12'h0D22, b);
    `CHK(b[0], 1'b1)
    rd(12'h0D20, b);
    `CHK(b[4], 1'b1)
    wr(12'h0D23, 8'h03);
    mp_clear <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    mp_clear <= 1'b0;
    rd(12'h0D20, b);
    `CHK(b[4], 1'b0)
    wr(12'h0D22, 8'h01);
    word <= C2;
    // Let the strobe drop before looking for the next one
    repeat (2) begin
      `WAIT(hist_strobe_o, 900)
      @(posedge sys_clk_i);
      #1;
    end
    rd48(12'h0D14, v);
    `CHK(v, C2)
    $display("Test averaging done");
    ref_en <= 4'h0;
    word <= C1;
    repeat (3) @(posedge sys_clk_i);
    #1;
    `CHK(synth_ftw_o, C2)
    `CHK(lock_o.phase, 1'b0)
    wr(12'h0A01, 8'h40);
    ref_en <= 4'h1;
    repeat (5) @(posedge sys_clk_i);
    #1;
    `CHK(synth_ftw_o, C2)
    wr(12'h0A01, 8'h00);
    `WAIT(profile_load_o, 10)
    `CHK(synth_ftw_o, C1)
    ref_en <= 4'h3;
    @(posedge sys_clk_i);
    ref_en <= 4'h2;
    repeat (4) @(posedge sys_clk_i);
    #1;
    `CHK(active_ref_o, 2'd1)
    ref_en <= 4'h0;
    repeat (3) @(posedge sys_clk_i);
    #1;
    `CHK(synth_ftw_o, FRW)
    $display("Test holdover and switchover done");
    ref_en <= 4'h1;
    wr(12'h031B, 8'h10);
    `WAIT(hist_strobe_o, 900)
    word <= C2;
    repeat (5) @(posedge sys_clk_i);
    wr(12'h0A03, 8'h04);
    ref_en <= 4'h0;
    repeat (3) @(posedge sys_clk_i);
    #1;
    `CHK(synth_ftw_o, C2)
    wr(12'h0A01, 8'h20);
    repeat (3) @(posedge sys_clk_i);
    #1;
    `CHK(synth_ftw_o, FRW)
    $display("Test clear and forced modes done");
    summarize();
  end
endmodule // dpll_holdover_history_control_tb_top
